/* File: include/raf_defines.vh */
// Constants for the reading average filter: register map, fields, defaults.
// Assumes inclusion by bare name from every file that needs these values.
`ifndef RAF_DEFINES_VH
`define RAF_DEFINES_VH

// Register byte offsets on the APB bus
`define RAF_OFF_CTRL 8'h00
`define RAF_OFF_SEL 8'h04
`define RAF_OFF_CFG 8'h08
`define RAF_OFF_STATUS 8'h0c
`define RAF_OFF_IRQ_STAT 8'h10
`define RAF_OFF_IRQ_MASK 8'h14

// Configuration word fields
`define RAF_CFG_COUNT_LSB 0
`define RAF_CFG_COUNT_MSB 6
`define RAF_CFG_REPEAT 7
`define RAF_CFG_NOWIN 8
`define RAF_CFG_ENABLE 9
`define RAF_CFG_WIN_LSB 16
`define RAF_CFG_WIN_MSB 25

// Status fields
`define RAF_ST_UNSETTLED 0
`define RAF_ST_FUNC_LSB 1
`define RAF_ST_FUNC_MSB 3
`define RAF_ST_INDICATOR 4
`define RAF_ST_SETTLED 8

// Interrupt status bits
`define RAF_IRQ_READING 0
`define RAF_IRQ_WINRESET 1
`define RAF_IRQ_SETTLED 2
`define RAF_IRQ_BITS 3

// Limits and reset values
`define RAF_NUM_FUNC 7
`define RAF_TEMP_FUNC 3'h6
`define RAF_COUNT_MIN 7'h01
`define RAF_COUNT_MAX 7'h64
`define RAF_COUNT_RST 7'h0a
`define RAF_WIN_MIN 10'h001
`define RAF_WIN_MAX 10'h3e8
`define RAF_WIN_RST 10'h00a
`define RAF_WIN_DEN 14'h2710

`endif

/* File: src/raf_filter.v */
// Reading average filter: moving or repeating average of conversions with
// a noise window, per-function setup, scan restrictions and APB registers.
// Assumes conversion stream, function, range and scan inputs on i_core_clk;
// the toggle key comes from a pin and is synchronised here.
`include "raf_defines.vh"

// Notes on behaviour
// - Count 1 to 100, average that many
// - Moving mode: newest displaces oldest conversion
// - Moving full stack: output every conversion
// - Repeating: collect, average once, restart empty
// - Count one: no averaging, window still tested in moving mode
// - Outside window: reset, output raw, fill stack
// - Window 0.01% to 10% or none
// - Temperature window uses sensor maximum reading
// - Settled bit 8, also when disabled
// - Pass readings while filling (repeating), flag unsettled
// - Separate setup per each of seven functions
// - Changes apply now if enabled, else later
// - Function or range change resets; function change reloads setup
// - Scanning forbids moving mode: filter disabled
// - Scanning ignores window, acts as none
// - Simple scan uses present count and state
// - Advanced scan: per-channel enable and count
// - Toggle key inverts enable, indicator follows outside scanning
module raf_filter #(
    parameter W = 24,
    parameter DEPTH = 100
) (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire i_conv_valid,
    input wire signed [W-1:0] i_conv_data,
    input wire [2:0] i_func,
    input wire [3:0] i_range,
    input wire [W-1:0] i_range_full,
    input wire [W-1:0] i_temp_max,
    input wire i_scan_active,
    input wire i_scan_advanced,
    input wire i_chan_enable,
    input wire [6:0] i_chan_count,
    input wire i_toggle_key,
    output reg o_rd_valid,
    output reg signed [W-1:0] o_rd_data,
    output reg o_rd_single,
    output reg o_settled,
    output reg o_unsettled,
    output reg o_filter_active_indicator,
    output reg o_irq
);
    localparam SW = W + 8;
    localparam NF = `RAF_NUM_FUNC;

    // Stored setup per function
    reg [6:0] st_count [0:NF-1];
    reg st_rep [0:NF-1];
    reg st_nowin [0:NF-1];
    reg st_en [0:NF-1];
    reg [9:0] st_win [0:NF-1];
    // Setup in force for the datapath
    reg [6:0] act_count;
    reg act_rep;
    reg act_nowin;
    reg [9:0] act_win;
    reg [2:0] cfg_sel;
    reg [`RAF_IRQ_BITS-1:0] irq_stat;
    reg [`RAF_IRQ_BITS-1:0] irq_mask;
    // Key synchroniser and edge detect
    reg key_s1;
    reg key_s2;
    reg key_s3;
    // Datapath state
    reg signed [W-1:0] stk [0:DEPTH-1];
    reg signed [SW-1:0] sum;
    reg signed [W-1:0] ref_conv;
    reg [6:0] wp;
    reg [6:0] new_cnt;
    reg loaded;
    reg settled;
    reg prev_en;
    reg [6:0] prev_count;
    reg prev_rep;
    reg [2:0] prev_func;
    reg [3:0] prev_range;
    reg ev_reading;
    reg ev_winreset;
    reg ev_settled;
    integer i;
    integer k;

    wire func_ok = (i_func < NF);
    wire [2:0] fidx = func_ok ? i_func : 3'h0;
    wire sel_ok = (cfg_sel < NF);
    wire apb_setup = i_psel && !i_penable && !o_pready;
    wire apb_done = i_psel && i_penable && o_pready;
    wire wr_en = apb_done && i_pwrite;
    wire key_edge = key_s2 && !key_s3;

    // Clamp a requested count into the legal span
    function [6:0] raf_clamp_count;
        input [6:0] c;
        begin
            if (c < `RAF_COUNT_MIN)
                raf_clamp_count = `RAF_COUNT_MIN;
            else if (c > `RAF_COUNT_MAX)
                raf_clamp_count = `RAF_COUNT_MAX;
            else
                raf_clamp_count = c;
        end
    endfunction

    // Clamp a window in units of 0.01 percent
    function [9:0] raf_clamp_win;
        input [9:0] v;
        begin
            if (v < `RAF_WIN_MIN)
                raf_clamp_win = `RAF_WIN_MIN;
            else if (v > `RAF_WIN_MAX)
                raf_clamp_win = `RAF_WIN_MAX;
            else
                raf_clamp_win = v;
        end
    endfunction

    // Effective enable, count and window under scan restrictions
    wire base_en = st_en[fidx];
    wire scan_en = i_scan_advanced ? i_chan_enable : base_en;
    wire eff_en = i_scan_active ? (scan_en && act_rep) : base_en;
    wire [6:0] eff_count = (i_scan_active && i_scan_advanced) ?
        raf_clamp_count(i_chan_count) : act_count;
    wire win_on = !act_nowin && !i_scan_active;

    // Window width in absolute units
    wire [W-1:0] full_scale = (fidx == `RAF_TEMP_FUNC) ?
        i_temp_max : i_range_full;
    wire [W+9:0] win_prod = {10'h000, full_scale} * {{W{1'b0}}, act_win};
    wire [W+9:0] win_div = win_prod / {{(W-4){1'b0}}, `RAF_WIN_DEN};
    wire signed [W:0] diff = {i_conv_data[W-1], i_conv_data} -
        {ref_conv[W-1], ref_conv};
    wire [W:0] abs_diff = diff[W] ? (~diff + {{W{1'b0}}, 1'b1}) : diff;
    wire out_win = win_on && loaded &&
        ({9'h000, abs_diff} > win_div);

    // Averaging arithmetic
    wire signed [SW-1:0] conv_ext = {{8{i_conv_data[W-1]}}, i_conv_data};
    wire signed [SW-1:0] old_ext = {{8{stk[wp][W-1]}}, stk[wp]};
    wire signed [SW-1:0] next_sum = act_rep ? (sum + conv_ext) :
        (sum + conv_ext - old_ext);
    wire signed [SW-1:0] cnt_ext = {{(SW-7){1'b0}}, eff_count};
    wire signed [SW-1:0] fill_sum = act_rep ? conv_ext :
        conv_ext * cnt_ext;
    wire signed [SW-1:0] avg = next_sum / cnt_ext;
    wire [6:0] next_cnt = new_cnt + 7'h01;
    wire [6:0] next_wp = (wp + 7'h01 >= eff_count) ? 7'h00 : wp + 7'h01;
    wire restart = (fidx != prev_func) || (i_range != prev_range) ||
        (eff_en != prev_en) || (eff_count != prev_count) ||
        (act_rep != prev_rep);
    wire first = !loaded || out_win;

    // Pin synchroniser for the toggle key
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            key_s1 <= 1'b0;
            key_s2 <= 1'b0;
            key_s3 <= 1'b0;
        end else begin
            key_s1 <= i_toggle_key;
            key_s2 <= key_s1;
            key_s3 <= key_s2;
        end
    end

    // Per-function setup store, selector and key toggle
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            cfg_sel <= 3'h0;
            for (i = 0; i < NF; i = i + 1) begin
                st_count[i] <= `RAF_COUNT_RST;
                st_rep[i] <= 1'b0;
                st_nowin[i] <= 1'b0;
                st_en[i] <= 1'b0;
                st_win[i] <= `RAF_WIN_RST;
            end
        end else begin
            if (wr_en && i_paddr == `RAF_OFF_SEL)
                cfg_sel <= i_pwdata[2:0];
            if (wr_en && i_paddr == `RAF_OFF_CFG && sel_ok) begin
                st_count[cfg_sel] <= raf_clamp_count(
                    i_pwdata[`RAF_CFG_COUNT_MSB:`RAF_CFG_COUNT_LSB]);
                st_rep[cfg_sel] <= i_pwdata[`RAF_CFG_REPEAT];
                st_nowin[cfg_sel] <= i_pwdata[`RAF_CFG_NOWIN];
                st_en[cfg_sel] <= i_pwdata[`RAF_CFG_ENABLE];
                st_win[cfg_sel] <= raf_clamp_win(
                    i_pwdata[`RAF_CFG_WIN_MSB:`RAF_CFG_WIN_LSB]);
            end
            if (wr_en && i_paddr == `RAF_OFF_CTRL && func_ok)
                st_en[fidx] <= i_pwdata[0];
            if (key_edge && func_ok)
                st_en[fidx] <= !st_en[fidx];
        end
    end

    // Setup in force follows the store while enabled and on a function change
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            act_count <= `RAF_COUNT_RST;
            act_rep <= 1'b0;
            act_nowin <= 1'b0;
            act_win <= `RAF_WIN_RST;
        end else if (base_en || fidx != prev_func) begin
            act_count <= st_count[fidx];
            act_rep <= st_rep[fidx];
            act_nowin <= st_nowin[fidx];
            act_win <= st_win[fidx];
        end
    end

    // Stack contents: fill all on reset, push in moving mode
    always @(posedge i_core_clk) begin
        if (i_conv_valid && eff_en && !restart) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                if (first)
                    stk[k] <= i_conv_data;
                else if (!act_rep && wp == k[6:0])
                    stk[k] <= i_conv_data;
            end
        end
    end

    // Averaging sequence and reading output
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            sum <= {SW{1'b0}};
            ref_conv <= {W{1'b0}};
            wp <= 7'h00;
            new_cnt <= 7'h00;
            loaded <= 1'b0;
            settled <= 1'b0;
            prev_en <= 1'b0;
            prev_count <= `RAF_COUNT_RST;
            prev_rep <= 1'b0;
            prev_func <= 3'h0;
            prev_range <= 4'h0;
            o_rd_valid <= 1'b0;
            o_rd_data <= {W{1'b0}};
            o_rd_single <= 1'b0;
            ev_reading <= 1'b0;
            ev_winreset <= 1'b0;
            ev_settled <= 1'b0;
        end else begin
            prev_en <= eff_en;
            prev_count <= eff_count;
            prev_rep <= act_rep;
            prev_func <= fidx;
            prev_range <= i_range;
            o_rd_valid <= 1'b0;
            ev_reading <= 1'b0;
            ev_winreset <= 1'b0;
            ev_settled <= 1'b0;
            if (restart) begin
                loaded <= 1'b0;
                new_cnt <= 7'h00;
                settled <= 1'b0;
                wp <= 7'h00;
            end else if (i_conv_valid) begin
                o_rd_valid <= 1'b1;
                ev_reading <= 1'b1;
                if (!eff_en) begin
                    o_rd_data <= i_conv_data;
                    o_rd_single <= 1'b1;
                end else if (first) begin
                    ref_conv <= i_conv_data;
                    sum <= fill_sum;
                    o_rd_data <= i_conv_data;
                    o_rd_single <= 1'b1;
                    ev_winreset <= out_win;
                    wp <= 7'h00;
                    new_cnt <= 7'h01;
                    loaded <= !(act_rep && eff_count == 7'h01);
                    settled <= (eff_count == 7'h01);
                    ev_settled <= (eff_count == 7'h01) && !settled;
                end else if (!act_rep) begin
                    sum <= next_sum;
                    wp <= next_wp;
                    o_rd_data <= avg[W-1:0];
                    o_rd_single <= 1'b0;
                    if (new_cnt < eff_count)
                        new_cnt <= next_cnt;
                    if (next_cnt >= eff_count) begin
                        settled <= 1'b1;
                        ev_settled <= !settled;
                    end
                end else if (next_cnt >= eff_count) begin
                    o_rd_data <= avg[W-1:0];
                    o_rd_single <= 1'b0;
                    sum <= {SW{1'b0}};
                    new_cnt <= 7'h00;
                    loaded <= 1'b0;
                    settled <= 1'b1;
                    ev_settled <= !settled;
                end else begin
                    sum <= next_sum;
                    new_cnt <= next_cnt;
                    o_rd_data <= i_conv_data;
                    o_rd_single <= 1'b1;
                end
            end
        end
    end

    // Status outputs
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_settled <= 1'b1;
            o_unsettled <= 1'b0;
            o_filter_active_indicator <= 1'b0;
        end else begin
            o_settled <= !eff_en || settled;
            o_unsettled <= eff_en && !settled;
            o_filter_active_indicator <= eff_en;
        end
    end

    // Interrupt status: set wins over write-one clear
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            irq_stat <= {`RAF_IRQ_BITS{1'b0}};
            irq_mask <= {`RAF_IRQ_BITS{1'b0}};
            o_irq <= 1'b0;
        end else begin
            if (wr_en && i_paddr == `RAF_OFF_IRQ_MASK)
                irq_mask <= i_pwdata[`RAF_IRQ_BITS-1:0];
            irq_stat <= (irq_stat & ~((wr_en &&
                i_paddr == `RAF_OFF_IRQ_STAT) ?
                i_pwdata[`RAF_IRQ_BITS-1:0] : {`RAF_IRQ_BITS{1'b0}})) |
                {ev_settled, ev_winreset, ev_reading};
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // APB slave: one wait-free access phase, error on unmapped
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
        end else begin
            o_pready <= apb_setup;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
            if (apb_setup) begin
                if (i_paddr == `RAF_OFF_CTRL) begin
                    o_prdata[0] <= base_en;
                end else if (i_paddr == `RAF_OFF_SEL) begin
                    o_prdata[2:0] <= cfg_sel;
                end else if (i_paddr == `RAF_OFF_CFG) begin
                    if (sel_ok) begin
                        o_prdata[`RAF_CFG_COUNT_MSB:`RAF_CFG_COUNT_LSB] <=
                            st_count[cfg_sel];
                        o_prdata[`RAF_CFG_REPEAT] <= st_rep[cfg_sel];
                        o_prdata[`RAF_CFG_NOWIN] <= st_nowin[cfg_sel];
                        o_prdata[`RAF_CFG_ENABLE] <= st_en[cfg_sel];
                        o_prdata[`RAF_CFG_WIN_MSB:`RAF_CFG_WIN_LSB] <=
                            st_win[cfg_sel];
                    end
                end else if (i_paddr == `RAF_OFF_STATUS) begin
                    o_prdata[`RAF_ST_UNSETTLED] <= o_unsettled;
                    o_prdata[`RAF_ST_FUNC_MSB:`RAF_ST_FUNC_LSB] <= fidx;
                    o_prdata[`RAF_ST_INDICATOR] <= o_filter_active_indicator;
                    o_prdata[`RAF_ST_SETTLED] <= o_settled;
                end else if (i_paddr == `RAF_OFF_IRQ_STAT) begin
                    o_prdata[`RAF_IRQ_BITS-1:0] <= irq_stat;
                end else if (i_paddr == `RAF_OFF_IRQ_MASK) begin
                    o_prdata[`RAF_IRQ_BITS-1:0] <= irq_mask;
                end else begin
                    o_pslverr <= 1'b1;
                end
            end
        end
    end
endmodule // raf_filter

/* File: tb/raf_adc_model.sv */
// Conversion source standing in for the converter on the far side.
// Assumes tasks are called just after a rising edge of i_core_clk.
module raf_adc_model (
    input wire logic i_core_clk,
    output logic o_conv_valid,
    output logic signed [23:0] o_conv_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_conv_valid = 1'h0;
        o_conv_data = 24'h5a5a5a;
    end

    // One conversion after a gap; data is scrambled outside the pulse
    task conv(input logic signed [23:0] x, input int gap);
        repeat (gap) @(posedge i_core_clk);
        o_conv_valid <= 1'h1;
        o_conv_data <= x;
        @(posedge i_core_clk);
        o_conv_valid <= 1'h0;
        o_conv_data <= ~x;
    endtask
endmodule // raf_adc_model

/* File: tb/raf_filter_sva.sv */
// Port checker for the reading average filter.
// Assumes it is bound to raf_filter and sees its ports only.
module raf_filter_sva #(
    parameter W = 24
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_conv_valid,
    input wire logic i_scan_active,
    input wire logic i_toggle_key,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_rd_valid,
    input wire logic signed [W-1:0] o_rd_data,
    input wire logic o_rd_single,
    input wire logic o_settled,
    input wire logic o_unsettled,
    input wire logic o_filter_active_indicator
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    // Reading stream
    a_rd_cause: assert property (o_rd_valid |-> $past(i_conv_valid))
        else $error("reading without a conversion");
    a_rd_hold: assert property (!o_rd_valid |-> $stable(o_rd_data))
        else $error("reading data moved without a pulse");
    // Settle flags and key toggle
    a_flags_apart: assert property (o_settled != o_unsettled)
        else $error("settled and unsettled agree");
    a_off_settled: assert property (
        !o_filter_active_indicator [*3] |-> o_settled)
        else $error("disabled filter not settled");
    a_key_flips: assert property (
        $rose(i_toggle_key) && !i_scan_active
        |-> ##[2:6] $changed(o_filter_active_indicator))
        else $error("key edge did not flip enable");
    // Register bus
    a_ready_next: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");

    c_avg: cover property (o_rd_valid && !o_rd_single);
    c_err: cover property (o_pslverr);
    c_settle: cover property ($fell(o_unsettled));
endmodule // raf_filter_sva

bind raf_filter raf_filter_sva #(.W(W)) i_sva (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_conv_valid(i_conv_valid),
    .i_scan_active(i_scan_active), .i_toggle_key(i_toggle_key),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_rd_single(o_rd_single),
    .o_settled(o_settled), .o_unsettled(o_unsettled),
    .o_filter_active_indicator(o_filter_active_indicator));

/* File: tb/raf_testbench.sv */
// Self-checking bench for the reading average filter.
// Assumes raf_adc_model drives the conversion stream.
`include "raf_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic key = 1'h0, scan = 1'h0, serr;
    logic adv = 1'h0, chen = 1'h0;
    logic [3:0] rng = 4'h2;
    logic [6:0] ccnt = 7'h00;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, cvv, rv, rs, st, ust, ind, irq;
    logic [2:0] func = 3'h0;
    logic [23:0] full = 24'h0003e8;
    logic signed [23:0] cvd, rd;
    int fail_count = 0, checks = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    raf_filter i_dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_conv_valid(cvv), .i_conv_data(cvd), .i_func(func),
        .i_range(rng), .i_range_full(full), .i_temp_max(24'h0002f8),
        .i_scan_active(scan), .i_scan_advanced(adv),
        .i_chan_enable(chen), .i_chan_count(ccnt), .i_toggle_key(key),
        .o_rd_valid(rv), .o_rd_data(rd), .o_rd_single(rs),
        .o_settled(st), .o_unsettled(ust),
        .o_filter_active_indicator(ind), .o_irq(irq));
    raf_adc_model i_adc (
        .i_core_clk(clk), .o_conv_valid(cvv), .o_conv_data(cvd));

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; the slave answers in the first access cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            n++;
            @(posedge clk);
        end
        chk("apb wait", n, 32'h0);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask

    // One conversion and the reading it yields a cycle later
    task cv(input int x, input int e, input logic s);
        i_adc.conv(x[23:0], x % 3);
        @(posedge clk);
        chk("rd valid", rv, 1'h1);
        chk("rd data", rd, e[23:0]);
        chk("rd single", rs, s);
    endtask

    task t_reset;
        apb(1'h0, `RAF_OFF_CFG, 32'h0);
        chk("count", rdat[6:0], 7'h0a);
        chk("window", rdat[25:16], 10'h00a);
        apb(1'h0, `RAF_OFF_STATUS, 32'h0);
        chk("settled", rdat[8], 1'h1);
        apb(1'h0, 8'h18, 32'h0);
        chk("unmapped", serr, 1'h1);
    endtask

    task t_moving;
        apb(1'h1, `RAF_OFF_SEL, 32'h0);
        apb(1'h1, `RAF_OFF_CFG, 32'h00000304);
        tick(3);
        cv(100, 100, 1'h1);
        tick(1);
        chk("filling", ust, 1'h1);
        cv(200, 125, 1'h0);
        cv(200, 150, 1'h0);
        cv(200, 175, 1'h0);
        tick(1);
        chk("full", st, 1'h1);
        cv(200, 200, 1'h0);
    endtask

    task t_scan_key;
        scan <= 1'h1;
        tick(3);
        chk("scan off", ind, 1'h0);
        scan <= 1'h0;
        tick(3);
        chk("scan end", ind, 1'h1);
        key <= 1'h1;
        tick(8);
        key <= 1'h0;
        chk("key", ind, 1'h0);
        apb(1'h0, `RAF_OFF_CTRL, 32'h0);
        chk("ctrl", rdat[0], 1'h0);
    endtask

    task t_repeat;
        apb(1'h1, `RAF_OFF_SEL, 32'h1);
        apb(1'h1, `RAF_OFF_CFG, 32'h00000383);
        func <= 3'h1;
        tick(3);
        cv(30, 30, 1'h1);
        cv(60, 60, 1'h1);
        cv(90, 60, 1'h0);
        cv(10, 10, 1'h1);
        apb(1'h1, `RAF_OFF_SEL, 32'h0);
        apb(1'h0, `RAF_OFF_CFG, 32'h0);
        chk("kept", rdat[6:0], 7'h04);
    endtask

    // Width 1000 * 10% of full scale 1000 gives 100
    task t_window;
        apb(1'h1, `RAF_OFF_IRQ_MASK, 32'h2);
        apb(1'h1, `RAF_OFF_SEL, 32'h2);
        apb(1'h1, `RAF_OFF_CFG, 32'h03e80204);
        func <= 3'h2;
        tick(3);
        cv(500, 500, 1'h1);
        cv(550, 512, 1'h0);
        cv(600, 537, 1'h0);
        apb(1'h1, `RAF_OFF_IRQ_STAT, 32'h7);
        cv(700, 700, 1'h1);
        tick(2);
        chk("irq", irq, 1'h1);
        apb(1'h1, `RAF_OFF_IRQ_STAT, 32'h7);
        tick(2);
        chk("irq clear", irq, 1'h0);
        cv(800, 725, 1'h0);
    endtask

    // Range change, scan limits, temperature window and count one
    task t_more;
        rng <= 4'h3;
        tick(3);
        cv(750, 750, 1'h1);
        apb(1'h1, `RAF_OFF_CFG, 32'h03e80284);
        adv <= 1'h1;
        chen <= 1'h1;
        ccnt <= 7'h02;
        scan <= 1'h1;
        tick(3);
        cv(100, 100, 1'h1);
        cv(900, 500, 1'h0);
        adv <= 1'h0;
        tick(3);
        cv(10, 10, 1'h1);
        cv(20, 20, 1'h1);
        cv(30, 30, 1'h1);
        cv(40, 25, 1'h0);
        scan <= 1'h0;
        apb(1'h1, `RAF_OFF_SEL, 32'h6);
        apb(1'h1, `RAF_OFF_CFG, 32'h03e80202);
        func <= 3'h6;
        tick(3);
        cv(500, 500, 1'h1);
        cv(590, 590, 1'h1);
        apb(1'h1, `RAF_OFF_CFG, 32'h03e80201);
        tick(3);
        cv(600, 600, 1'h1);
        cv(650, 650, 1'h0);
        cv(800, 800, 1'h1);
    endtask

    task tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        tick(2);
        rstn <= 1'h1;
        tick(1);
        t_reset;
        t_moving;
        t_scan_key;
        t_repeat;
        t_window;
        t_more;
        tally_and_finish;
    end

    // Watchdog
    initial begin
        tick(5000);
        fail_count++;
        tally_and_finish;
    end
endmodule // testbench
